// >>> src/relay_io_defines.svh
// register map, field positions, reset values and timing figures of the digital i/o block
`ifndef RELAY_IO_DEFINES_SVH
`define RELAY_IO_DEFINES_SVH
`define ADDR_CTRL 8'h00
`define ADDR_POLARITY 8'h04
`define ADDR_DELAY 8'h08
`define ADDR_ON_EV_EN 8'h0c
`define ADDR_OFF_EV_EN 8'h10
`define ADDR_ALARM_EN 8'h14
`define ADDR_IN_STATE 8'h18
`define ADDR_OUT_STATE 8'h1c
`define ADDR_XS_STEP 8'h20
`define ADDR_XS_ROW 8'h24
`define ADDR_OUT_LATCH 8'h28
`define ADDR_EV_STATUS 8'h2c
`define ADDR_EV_CLEAR 8'h30
`define ADDR_EV_ENABLE 8'h34
`define ADDR_POPUP 8'h38
`define ADDR_CNT_SEL 8'h3c
`define ADDR_CNT_DATA 8'h40
`define CTRL_FORCE_BIT 0
`define CTRL_AC_BIT 1
`define CTRL_RELEASE_BIT 2
`define XS_ROW_LSB 0
`define XS_COL_LSB 8
`define DELAY_MAX 13'd6000
`define DELAY_UNIT_NS 10000000
`define CLK_PERIOD_NS 10
`define DELAY_RST 13'h0000
`endif

// >>> src/relay_io_pkg.sv
// types shared by the digital i/o block
package relay_io_pkg;
	typedef enum logic [2:0] {
		XS_OPEN = 3'b001,
		XS_CONN = 3'b010,
		XS_LATCH = 3'b100
	} xs_state_t;
endpackage

// >>> src/relay_digital_io.sv
// field input conditioning, output matrix and contact drive with register port
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`include "relay_io_defines.svh"
module relay_digital_io import relay_io_pkg::*; #(
	parameter int N_IN = 16,
	parameter int N_SIG = 32,
	parameter int N_TRIP = 7,
	parameter int TICK_CYC = `DELAY_UNIT_NS / `CLK_PERIOD_NS
) (
	input wire logic clk_sys, // system clock 100 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	input wire logic [N_IN-1:0] field_input, // raw field contacts
	input wire logic [N_SIG-1:0] int_signal, // internal protection/logic signals
	input wire logic enter_key, // front panel enter key pulse
	input wire logic release_all, // common release from input or remote
	output logic [N_TRIP-1:0] trip_output, // trip contacts
	output logic alarm_signal_output, // alarm signalling contact
	output logic service_status_output, // service status contact
	output logic [N_IN-1:0] in_state, // conditioned input states
	output logic ac_mode, // input supply mode, 1 = ac
	output logic irq // level interrupt
);
	localparam int N_OUT = N_TRIP + 2;
	localparam int N_ROW = N_SIG + N_IN;
	localparam int TW = $clog2(TICK_CYC + 1);

	logic force_q, ac_q;
	logic [N_IN-1:0] pol_q, on_en_q, off_en_q, alarm_en_q;
	logic [12:0] delay_q;
	logic [N_IN-1:0] raw_q, state_q, popup_q;
	logic [12:0] tmr_q [N_IN];
	logic [15:0] cnt_q [N_IN];
	logic [3:0] cnt_sel_q;
	logic [31:0] ev_status_q, ev_en_q;
	logic [TW-1:0] pre_q;
	logic tick;
	xs_state_t xs_q [N_ROW][N_OUT];
	logic [5:0] xs_row_q;
	logic [N_OUT-1:0] out_latch_q, latch_q, force_val_q, out_q, drive, latch_set;
	logic [N_ROW-1:0] rows;
	logic [N_IN-1:0] act, rise, fall, prev_q;
	logic release_any, cnt_wr;
	logic [31:0] rd_d;

	assign act = field_input ^ pol_q;
	// conditioned edges, seen in the cycle after the state commits
	assign rise = state_q & ~prev_q;
	assign fall = ~state_q & prev_q;
	assign rows = {state_q, int_signal};
	assign release_any = enter_key | release_all | (wr && addr == `ADDR_CTRL && wdata[`CTRL_RELEASE_BIT]);
	assign cnt_wr = wr && addr == `ADDR_CNT_DATA;
	assign tick = (pre_q == TW'(TICK_CYC - 1));
	assign in_state = state_q;
	assign ac_mode = ac_q;
	assign trip_output = out_q[N_TRIP-1:0];
	assign alarm_signal_output = out_q[N_TRIP];
	assign service_status_output = out_q[N_TRIP+1];
	assign irq = |(ev_status_q & ev_en_q);

	// configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			force_q <= 1'b0;
			ac_q <= 1'b0;
			pol_q <= '0;
			on_en_q <= '0;
			off_en_q <= '0;
			alarm_en_q <= '0;
			delay_q <= `DELAY_RST;
			out_latch_q <= '0;
			ev_en_q <= '0;
			cnt_sel_q <= 4'h0;
			xs_row_q <= 6'h00;
		end else if (wr) begin
			if (addr == `ADDR_CTRL) begin
				force_q <= wdata[`CTRL_FORCE_BIT];
				ac_q <= wdata[`CTRL_AC_BIT];
			end else if (addr == `ADDR_POLARITY) begin
				pol_q <= wdata[N_IN-1:0];
			end else if (addr == `ADDR_DELAY) begin
				delay_q <= (wdata > 32'(`DELAY_MAX)) ? `DELAY_MAX : wdata[12:0];
			end else if (addr == `ADDR_ON_EV_EN) begin
				on_en_q <= wdata[N_IN-1:0];
			end else if (addr == `ADDR_OFF_EV_EN) begin
				off_en_q <= wdata[N_IN-1:0];
			end else if (addr == `ADDR_ALARM_EN) begin
				alarm_en_q <= wdata[N_IN-1:0];
			end else if (addr == `ADDR_OUT_LATCH) begin
				out_latch_q <= wdata[N_OUT-1:0];
			end else if (addr == `ADDR_EV_ENABLE) begin
				ev_en_q <= wdata;
			end else if (addr == `ADDR_CNT_SEL) begin
				cnt_sel_q <= wdata[3:0];
			end else if (addr == `ADDR_XS_ROW) begin
				xs_row_q <= wdata[5:0];
			end
		end
	end

	// delay tick prescaler, one tick per hundredth of a second
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= '0;
		end else begin
			pre_q <= tick ? '0 : pre_q + 1'b1;
		end
	end

	// per-input delay timer and conditioned state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			raw_q <= '0;
			state_q <= '0;
			for (int i = 0; i < N_IN; i++) begin
				tmr_q[i] <= 13'h0000;
			end
		end else begin
			raw_q <= act;
			for (int i = 0; i < N_IN; i++) begin
				if (act[i] != raw_q[i] || raw_q[i] == state_q[i]) begin
					tmr_q[i] <= 13'h0000;
				end else if (tmr_q[i] >= delay_q) begin
					state_q[i] <= raw_q[i];
					tmr_q[i] <= 13'h0000;
				end else if (tick) begin
					tmr_q[i] <= tmr_q[i] + 13'h0001;
				end
			end
		end
	end

	// event flags, pop-up flags; hardware set wins over software clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ev_status_q <= '0;
			popup_q <= '0;
		end else begin
			ev_status_q <= (ev_status_q & ~((wr && addr == `ADDR_EV_CLEAR) ? wdata : 32'h0))
				| {16'(fall & off_en_q), 16'(rise & on_en_q)};
			popup_q <= (release_any ? '0 : popup_q & ~((wr && addr == `ADDR_POPUP) ? wdata[N_IN-1:0] : '0))
				| (rise & alarm_en_q);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
		end else begin
			prev_q <= state_q;
		end
	end

	// active-edge counters, configuration write has priority
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N_IN; i++) begin
				cnt_q[i] <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < N_IN; i++) begin
				if (cnt_wr && cnt_sel_q == 4'(i)) begin
					cnt_q[i] <= wdata[15:0];
				end else if (rise[i]) begin
					cnt_q[i] <= cnt_q[i] + 16'h0001;
				end
			end
		end
	end

	// crossing matrix: each selection steps open -> connected -> latched -> open
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int r = 0; r < N_ROW; r++) begin
				for (int c = 0; c < N_OUT; c++) begin
					xs_q[r][c] <= XS_OPEN;
				end
			end
		end else if (wr && addr == `ADDR_XS_STEP) begin
			for (int r = 0; r < N_ROW; r++) begin
				for (int c = 0; c < N_OUT; c++) begin
					if (wdata[`XS_ROW_LSB +: 6] == 6'(r) && wdata[`XS_COL_LSB +: 4] == 4'(c)) begin
						case (xs_q[r][c])
							XS_OPEN: xs_q[r][c] <= XS_CONN;
							XS_CONN: xs_q[r][c] <= XS_LATCH;
							default: xs_q[r][c] <= XS_OPEN;
						endcase
					end
				end
			end
		end
	end

	always_comb begin
		drive = '0;
		latch_set = '0;
		for (int c = 0; c < N_OUT; c++) begin
			for (int r = 0; r < N_ROW; r++) begin
				if (rows[r] && xs_q[r][c] != XS_OPEN) begin
					drive[c] = 1'b1;
				end
				if (rows[r] && (xs_q[r][c] == XS_LATCH || (xs_q[r][c] == XS_CONN && out_latch_q[c]))) begin
					latch_set[c] = 1'b1;
				end
			end
		end
	end

	// latch memory, force values and contact drive
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= '0;
			force_val_q <= '0;
			out_q <= '0;
		end else begin
			latch_q <= (release_any ? '0 : latch_q) | latch_set;
			if (wr && addr == `ADDR_OUT_STATE && force_q) begin
				force_val_q <= wdata[N_OUT-1:0];
			end
			out_q <= force_q ? force_val_q : (drive | latch_q);
		end
	end

	// read mux, data valid only in the cycle after the strobe
	always_comb begin
		rd_d = 32'h0;
		if (addr == `ADDR_CTRL) begin
			rd_d = {29'h0, 1'b0, ac_q, force_q};
		end else if (addr == `ADDR_POLARITY) begin
			rd_d = 32'(pol_q);
		end else if (addr == `ADDR_DELAY) begin
			rd_d = 32'(delay_q);
		end else if (addr == `ADDR_ON_EV_EN) begin
			rd_d = 32'(on_en_q);
		end else if (addr == `ADDR_OFF_EV_EN) begin
			rd_d = 32'(off_en_q);
		end else if (addr == `ADDR_ALARM_EN) begin
			rd_d = 32'(alarm_en_q);
		end else if (addr == `ADDR_IN_STATE) begin
			rd_d = 32'(state_q);
		end else if (addr == `ADDR_OUT_STATE) begin
			rd_d = 32'(out_q);
		end else if (addr == `ADDR_XS_ROW) begin
			for (int c = 0; c < N_OUT; c++) begin
				if (xs_row_q < 6'(N_ROW)) begin
					rd_d[2*c +: 2] = (xs_q[xs_row_q][c] == XS_CONN) ? 2'h1
						: (xs_q[xs_row_q][c] == XS_LATCH) ? 2'h2 : 2'h0;
				end
			end
		end else if (addr == `ADDR_OUT_LATCH) begin
			rd_d = 32'(out_latch_q);
		end else if (addr == `ADDR_EV_STATUS) begin
			rd_d = ev_status_q;
		end else if (addr == `ADDR_EV_ENABLE) begin
			rd_d = ev_en_q;
		end else if (addr == `ADDR_POPUP) begin
			rd_d = 32'(popup_q);
		end else if (addr == `ADDR_CNT_SEL) begin
			rd_d = 32'(cnt_sel_q);
		end else if (addr == `ADDR_CNT_DATA) begin
			rd_d = 32'(cnt_q[cnt_sel_q]);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0;
		end else begin
			rdata <= rd ? rd_d : 32'h0;
		end
	end

	a_state_follows_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q[0] != $past(state_q[0])) |-> state_q[0] == $past(raw_q[0]))
		else $error("input state changed to a level that was not the active-corrected input");
	a_delay_expired: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q[0] != $past(state_q[0])) |-> $past(tmr_q[0]) >= $past(delay_q))
		else $error("input state committed before its delay expired");
	a_on_event_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(state_q[0]) && on_en_q[0] |=> ev_status_q[0])
		else $error("enabled active-edge event not flagged");
	a_on_event_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(state_q[0]) && !on_en_q[0] && !ev_status_q[0] |=> !ev_status_q[0])
		else $error("disabled active-edge event was flagged");
	a_off_event_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(state_q[0]) && off_en_q[0] |=> ev_status_q[16])
		else $error("enabled inactive-edge event not flagged");
	a_popup_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(state_q[0]) && alarm_en_q[0] |=> popup_q[0])
		else $error("alarm pop-up not raised at active edge");
	a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(state_q[0]) && !cnt_wr |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
		else $error("active-edge counter did not step by one");
	a_crossing_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr && addr == `ADDR_XS_STEP && wdata[13:0] == 14'h0000 && xs_q[0][0] == XS_OPEN |=> xs_q[0][0] == XS_CONN)
		else $error("crossing did not step from open to connected");
	a_release_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		release_any && latch_set == '0 |=> latch_q == '0)
		else $error("release did not clear latched outputs");
	a_force_drives: assert property (@(posedge clk_sys) disable iff (!rst_n)
		force_q ##1 force_q |-> out_q == $past(force_val_q))
		else $error("forced output does not show the forced value");
	a_matrix_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!force_q && latch_q == '0 |=> out_q == $past(drive))
		else $error("unforced output does not follow the matrix");
endmodule

// >>> tb/field_model.sv
// partner model: field contacts and internal protection signals
`timescale 1ns/1ns
module field_model (
	input wire logic clk_sys, // system clock
	output logic [15:0] field_input, // contact levels
	output logic [31:0] int_signal // internal signal levels
);
	initial begin
		field_input = 16'h0000;
		int_signal = 32'h0000_0000;
	end
	// levels change only just after a clock edge
	task automatic set_in(input int i, input logic v);
		@(posedge clk_sys);
		field_input[i] <= v;
	endtask
	task automatic set_sig(input int i, input logic v);
		@(posedge clk_sys);
		int_signal[i] <= v;
	endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the digital i/o block
`timescale 1ns/1ns
`include "relay_io_defines.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	localparam int TICK = 4;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [15:0] field_input;
	logic [31:0] int_signal;
	logic enter_key = 1'b0;
	logic release_all = 1'b0;
	logic [6:0] trip_output;
	logic alarm_signal_output;
	logic service_status_output;
	logic [15:0] in_state;
	logic ac_mode;
	logic irq;
	int n_errors = 0;
	int n_checks = 0;
	int cyc_cnt = 0;
	logic [31:0] d;
	int k;
	always #5 clk_sys = ~clk_sys;
	field_model u_field_model (.clk_sys(clk_sys), .field_input(field_input), .int_signal(int_signal));
	relay_digital_io #(.TICK_CYC(TICK)) u_relay_digital_io (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .field_input(field_input), .int_signal(int_signal),
		.enter_key(enter_key), .release_all(release_all), .trip_output(trip_output),
		.alarm_signal_output(alarm_signal_output), .service_status_output(service_status_output),
		.in_state(in_state), .ac_mode(ac_mode), .irq(irq));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic pulse(input int which);
		@(posedge clk_sys);
		if (which == 0) enter_key <= 1'b1; else release_all <= 1'b1;
		@(posedge clk_sys);
		enter_key <= 1'b0;
		release_all <= 1'b0;
		cyc(2);
	endtask
	task automatic t_reset;
		rreg(`ADDR_IN_STATE, d); `CHK("in_state reg", 32'h0, d)
		rreg(`ADDR_EV_STATUS, d); `CHK("ev_status", 32'h0, d)
		rreg(8'h44, d); `CHK("unmapped read", 32'h0, d)
		`CHK("irq idle", 1'b0, irq)
	endtask
	task automatic t_edges;
		wreg(`ADDR_ON_EV_EN, 32'h1);
		wreg(`ADDR_ALARM_EN, 32'h1);
		wreg(`ADDR_EV_ENABLE, 32'hffff_ffff);
		u_field_model.set_in(0, 1'b1); cyc(5);
		`CHK("in_state0 no", 1'b1, in_state[0])
		rreg(`ADDR_EV_STATUS, d); `CHK("active event", 32'h1, d)
		rreg(`ADDR_POPUP, d); `CHK("popup", 32'h1, d)
		`CHK("irq set", 1'b1, irq)
		wreg(`ADDR_EV_ENABLE, 32'h0); cyc(1);
		`CHK("irq masked", 1'b0, irq)
		wreg(`ADDR_EV_ENABLE, 32'hffff_ffff);
		wreg(`ADDR_CNT_SEL, 32'h0);
		rreg(`ADDR_CNT_DATA, d); `CHK("counter one", 32'h1, d)
		wreg(`ADDR_EV_CLEAR, 32'hffff_ffff); cyc(1);
		`CHK("irq clear", 1'b0, irq)
		u_field_model.set_in(0, 1'b0); cyc(5);
		rreg(`ADDR_EV_STATUS, d); `CHK("off event masked", 32'h0, d)
		wreg(`ADDR_OFF_EV_EN, 32'h1);
		wreg(`ADDR_POPUP, 32'h1);
		wreg(`ADDR_ALARM_EN, 32'h0);
		u_field_model.set_in(0, 1'b1); cyc(5);
		u_field_model.set_in(0, 1'b0); cyc(5);
		rreg(`ADDR_EV_STATUS, d); `CHK("both events", 32'h1_0001, d)
		rreg(`ADDR_POPUP, d); `CHK("popup off", 32'h0, d)
		rreg(`ADDR_CNT_DATA, d); `CHK("counter two", 32'h2, d)
		wreg(`ADDR_EV_CLEAR, 32'hffff_ffff);
	endtask
	task automatic t_nc;
		wreg(`ADDR_ON_EV_EN, 32'h2);
		wreg(`ADDR_POLARITY, 32'h2); cyc(4);
		`CHK("nc low active", 1'b1, in_state[1])
		wreg(`ADDR_EV_CLEAR, 32'hffff_ffff);
		u_field_model.set_in(1, 1'b1); cyc(5);
		`CHK("nc high idle", 1'b0, in_state[1])
		rreg(`ADDR_EV_STATUS, d); `CHK("nc rise no event", 32'h0, d)
		u_field_model.set_in(1, 1'b0); cyc(5);
		rreg(`ADDR_EV_STATUS, d); `CHK("nc fall event", 32'h2, d)
		wreg(`ADDR_POLARITY, 32'h0);
		wreg(`ADDR_EV_CLEAR, 32'hffff_ffff);
	endtask
	task automatic t_delay;
		wreg(`ADDR_DELAY, 32'd7000);
		rreg(`ADDR_DELAY, d); `CHK("delay clamp", 32'd6000, d)
		wreg(`ADDR_DELAY, 32'd2);
		u_field_model.set_in(2, 1'b1); cyc(3);
		u_field_model.set_in(2, 1'b0); cyc(20);
		`CHK("short pulse", 1'b0, in_state[2])
		u_field_model.set_in(2, 1'b1);
		for (k = 0; k < 30 && in_state[2] !== 1'b1; k++) cyc(1);
		`CHK("on delayed", 1'b1, in_state[2])
		`CHK("on not early", 1'b1, k >= 2 * TICK - 2)
		u_field_model.set_in(2, 1'b0); cyc(4);
		`CHK("off delayed", 1'b1, in_state[2])
		cyc(20);
		`CHK("off done", 1'b0, in_state[2])
		wreg(`ADDR_DELAY, 32'd0);
	endtask
	task automatic t_counter;
		wreg(`ADDR_CNT_SEL, 32'h3);
		wreg(`ADDR_CNT_DATA, 32'hffff);
		rreg(`ADDR_CNT_DATA, d); `CHK("counter load", 32'hffff, d)
		u_field_model.set_in(3, 1'b1); cyc(5);
		rreg(`ADDR_CNT_DATA, d); `CHK("counter wrap", 32'h0, d)
		rreg(`ADDR_EV_STATUS, d); `CHK("on event disabled", 32'h0, d)
		u_field_model.set_in(3, 1'b0);
		wreg(`ADDR_EV_CLEAR, 32'hffff_ffff);
	endtask
	task automatic sig_pulse(input int i);
		u_field_model.set_sig(i, 1'b1); cyc(2);
		u_field_model.set_sig(i, 1'b0); cyc(2);
	endtask
	task automatic t_matrix;
		wreg(`ADDR_XS_STEP, 32'h0);
		wreg(`ADDR_XS_ROW, 32'h0);
		rreg(`ADDR_XS_ROW, d); `CHK("xs conn", 32'h1, d)
		u_field_model.set_sig(0, 1'b1); cyc(2);
		`CHK("trip follows", 7'h01, trip_output)
		u_field_model.set_sig(0, 1'b0); cyc(2);
		`CHK("trip drops", 7'h00, trip_output)
		wreg(`ADDR_XS_STEP, 32'h0);
		rreg(`ADDR_XS_ROW, d); `CHK("xs latch", 32'h2, d)
		sig_pulse(0);
		`CHK("trip held", 7'h01, trip_output)
		wreg(`ADDR_CTRL, 32'h4); cyc(2);
		`CHK("tool release", 7'h00, trip_output)
		wreg(`ADDR_XS_STEP, 32'h0);
		rreg(`ADDR_XS_ROW, d); `CHK("xs open", 32'h0, d)
		wreg(`ADDR_XS_STEP, 32'h0801);
		wreg(`ADDR_OUT_LATCH, 32'h100);
		sig_pulse(1);
		`CHK("svc latched", 1'b1, service_status_output)
		pulse(1);
		`CHK("release all", 1'b0, service_status_output)
		sig_pulse(1);
		pulse(0);
		`CHK("enter key", 1'b0, service_status_output)
		wreg(`ADDR_XS_STEP, 32'h0720);
		u_field_model.set_in(0, 1'b1); cyc(5);
		`CHK("input to alarm", 1'b1, alarm_signal_output)
		u_field_model.set_in(0, 1'b0); cyc(5);
		`CHK("alarm drops", 1'b0, alarm_signal_output)
	endtask
	task automatic t_force;
		wreg(`ADDR_OUT_STATE, 32'h1ff); cyc(2);
		`CHK("no force", 9'h000, {service_status_output, alarm_signal_output, trip_output})
		wreg(`ADDR_CTRL, 32'h1);
		wreg(`ADDR_OUT_STATE, 32'h1ff); cyc(2);
		`CHK("forced", 9'h1ff, {service_status_output, alarm_signal_output, trip_output})
		rreg(`ADDR_OUT_STATE, d); `CHK("forced read", 32'h1ff, d)
		wreg(`ADDR_CTRL, 32'h2); cyc(2);
		`CHK("force off", 9'h000, {service_status_output, alarm_signal_output, trip_output})
		`CHK("ac mode", 1'b1, ac_mode)
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_edges();
		t_nc();
		t_delay();
		t_counter();
		t_matrix();
		t_force();
		wrap_up();
	end
endmodule
